// [slice_ctl_cfg.svh]
// Timing counts and widths for the bus slice controller.
// Assumes a 40 MHz clk; the assertions and the bench hard-code counts and a half period derived from these figures.
`ifndef SLICE_CTL_CFG_SVH
`define SLICE_CTL_CFG_SVH

`define SC_CLK_PERIOD_NS 25
`define SC_BYTE_W        8
`define SC_FIFO_DEPTH    8
`define SC_SLICES        1
// Each phase of a pin sequence lasts at least this long.
`define SC_STEP_NS       100
`define SC_STEP_CYC      ((`SC_STEP_NS + `SC_CLK_PERIOD_NS - 1) / `SC_CLK_PERIOD_NS)
// A merged match must stand this long before it is believed.
`define SC_MATCH_FILT_NS 75
`define SC_MATCH_FILT_CYC ((`SC_MATCH_FILT_NS + `SC_CLK_PERIOD_NS - 1) / `SC_CLK_PERIOD_NS)

`endif

// [slice_ctl_pkg.sv]
// Types shared by the bus slice controller and its user.
// Assumes nothing beyond the constants header.
package slice_ctl_pkg;

   typedef enum logic [2:0] {
      OP_LOAD_MASK = 3'h0,
      OP_LOAD_CMP  = 3'h1,
      OP_WRITE     = 3'h2,
      OP_READ      = 3'h3,
      OP_INC_VME   = 3'h4,
      OP_INC_LOCAL = 3'h5,
      OP_INC_SLAVE = 3'h6
   } op_t;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_DRIVE   = 5'h02,
      ST_LATCH   = 5'h04,
      ST_SAMPLE  = 5'h08,
      ST_RELEASE = 5'h10
   } state_t;

   typedef struct packed {
      op_t        op;
      logic [7:0] addr;
      logic [7:0] data;
   } cmd_t;

   typedef struct packed {
      logic       data_in_latch_ctl;
      logic       data_out_latch_ctl;
      logic       addr_out_latch_ctl;
      logic       addr_in_latch_ctl;
      logic       local_carry_in_n;
      logic       vme_carry_in_n;
      logic       bus_request_decode_n;
      logic       block_xfer_ctl_n;
      logic       data_in_enable_n;
      logic       data_in_enable2_n;
      logic       data_out_enable_n;
      logic       vme_addr_out_enable_n;
      logic       local_data_select;
      logic       reg_strobe_n;
      logic       local_data_oe;
      logic [7:0] local_address;
      logic [7:0] local_data_o;
   } pins_t;

endpackage : slice_ctl_pkg

// [byte_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low synchronous reset.
`timescale 1ns/100ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             push;
   logic             pop;

   assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr_r != rd_ptr_r;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr_r[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule : byte_fifo

// [vme_slice_ctl.sv]
// Controller that drives the control pins of an eight-bit bus slice.
// Assumes the slice is wired as the least significant one of its chain
// and that compare outputs of all slices arrive here unsynchronised.
//
// Contract
// - Mask or compare loads only with strobe low and decode high.
// - Data select high loads compare register, low loads mask register.
// - Compare-match glitches; outside logic must filter it.
// - Outside logic merges compare-match outputs of several slices.
// - Carry-ins chain from carry-outs of the next less significant slice.
`timescale 1ns/100ps
`include "slice_ctl_cfg.svh"
module vme_slice_ctl #(
   parameter int SLICES = `SC_SLICES
) (
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  cmd_valid,
   output logic                       cmd_ready,
   input  wire slice_ctl_pkg::cmd_t   cmd,
   output logic                 [7:0] rd_data,
   output logic                       rd_valid,
   input  wire logic                  rd_ready,
   output logic                       busy,
   output logic                       addr_match,
   output logic                       vme_count_max,
   output logic                       local_count_max,
   output slice_ctl_pkg::pins_t       slice_pins,
   input  wire logic            [7:0] local_data_i,
   input  wire logic     [SLICES-1:0] compare_match_n,
   input  wire logic                  vme_carry_out_n,
   input  wire logic                  local_carry_out_n
);
   localparam logic [2:0] STEP_CYC = 3'(`SC_STEP_CYC);
   localparam logic [2:0] FILT_CYC = 3'(`SC_MATCH_FILT_CYC);

   slice_ctl_pkg::state_t state_r;
   slice_ctl_pkg::state_t state_nxt;
   slice_ctl_pkg::cmd_t   cmd_r;
   slice_ctl_pkg::pins_t  pins_r;
   slice_ctl_pkg::pins_t  pins_nxt;
   logic [2:0]            step_cnt_r;
   logic                  step_en;
   logic                  accept;
   logic                  fifo_in_ready;
   logic                  fifo_push;
   logic [7:0]            ld_s1_r;
   logic [7:0]            ld_s2_r;
   logic [SLICES-1:0]     cm_s1_r;
   logic [SLICES-1:0]     cm_s2_r;
   logic [1:0]            co_s1_r;
   logic [1:0]            co_s2_r;
   logic                  merged_match;
   logic                  match_prev_r;
   logic [2:0]            stab_cnt_r;
   logic                  addr_match_r;

   // Pin levels for a given phase of a command; idle leaves all inactive.
   function automatic slice_ctl_pkg::pins_t pins_for(
      input slice_ctl_pkg::state_t st,
      input slice_ctl_pkg::cmd_t   c
   );
      slice_ctl_pkg::pins_t p;
      logic                 held;
      p = '{default: 1'b0, local_address: c.addr, local_data_o: c.data};
      p.local_carry_in_n      = 1'b1;
      p.vme_carry_in_n        = 1'b1;
      p.bus_request_decode_n  = 1'b1;
      p.block_xfer_ctl_n      = 1'b1;
      p.data_in_enable_n      = 1'b1;
      p.data_in_enable2_n     = 1'b1;
      p.data_out_enable_n     = 1'b1;
      p.vme_addr_out_enable_n = 1'b1;
      p.reg_strobe_n          = 1'b1;
      held = (st == slice_ctl_pkg::ST_LATCH) ||
             (st == slice_ctl_pkg::ST_SAMPLE);
      if ((st != slice_ctl_pkg::ST_IDLE) && (st != slice_ctl_pkg::ST_RELEASE))
      begin
         case (c.op)
            slice_ctl_pkg::OP_LOAD_MASK,
            slice_ctl_pkg::OP_LOAD_CMP:
            begin
               p.local_data_oe     = 1'b1;
               p.local_data_select = (c.op == slice_ctl_pkg::OP_LOAD_CMP);
               p.reg_strobe_n      = !held;
            end
            slice_ctl_pkg::OP_WRITE:
            begin
               p.bus_request_decode_n  = 1'b0;
               p.local_data_oe         = 1'b1;
               p.vme_addr_out_enable_n = 1'b0;
               p.data_out_enable_n     = 1'b0;
               p.addr_out_latch_ctl    = held;
               p.data_out_latch_ctl    = held;
            end
            slice_ctl_pkg::OP_READ:
            begin
               p.bus_request_decode_n  = 1'b0;
               p.vme_addr_out_enable_n = 1'b0;
               p.data_in_enable_n      = 1'b0;
               p.data_in_enable2_n     = 1'b0;
               p.addr_out_latch_ctl    = held;
               p.data_in_latch_ctl     = held;
            end
            slice_ctl_pkg::OP_INC_VME:
            begin
               // The latch rises only after carry-in is low, so the
               // slice counts on the rising edge with dual path clear.
               // As the least significant slice this controller is the
               // head of the carry chain and enables the count itself.
               p.vme_carry_in_n     = 1'b0;
               p.addr_out_latch_ctl = held;
            end
            slice_ctl_pkg::OP_INC_LOCAL:
            begin
               p.local_carry_in_n = 1'b0;
               p.block_xfer_ctl_n = !held;
            end
            slice_ctl_pkg::OP_INC_SLAVE:
            begin
               p.local_carry_in_n  = 1'b0;
               p.addr_in_latch_ctl = held;
            end
            default:
            begin
               p.reg_strobe_n = 1'b1;
            end
         endcase
      end
      return p;
   endfunction : pins_for

   assign cmd_ready = (state_r == slice_ctl_pkg::ST_IDLE) &&
                      ((cmd.op != slice_ctl_pkg::OP_READ) || fifo_in_ready);
   assign accept    = cmd_valid && cmd_ready;
   assign busy      = state_r != slice_ctl_pkg::ST_IDLE;
   assign step_en   = busy && (step_cnt_r == 3'h0);
   assign fifo_push = step_en && (state_r == slice_ctl_pkg::ST_SAMPLE) &&
                      (cmd_r.op == slice_ctl_pkg::OP_READ);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         slice_ctl_pkg::ST_IDLE:
         begin
            if (accept)
            begin
               state_nxt = slice_ctl_pkg::ST_DRIVE;
            end
         end
         slice_ctl_pkg::ST_DRIVE:
         begin
            if (step_en)
            begin
               state_nxt = slice_ctl_pkg::ST_LATCH;
            end
         end
         slice_ctl_pkg::ST_LATCH:
         begin
            if (step_en)
            begin
               state_nxt = slice_ctl_pkg::ST_SAMPLE;
            end
         end
         slice_ctl_pkg::ST_SAMPLE:
         begin
            if (step_en)
            begin
               state_nxt = slice_ctl_pkg::ST_RELEASE;
            end
         end
         slice_ctl_pkg::ST_RELEASE:
         begin
            if (step_en)
            begin
               state_nxt = slice_ctl_pkg::ST_IDLE;
            end
         end
         default:
         begin
            state_nxt = slice_ctl_pkg::ST_IDLE;
         end
      endcase
   end

   assign pins_nxt = pins_for(state_nxt, accept ? cmd : cmd_r);

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_r <= slice_ctl_pkg::ST_IDLE;
         cmd_r   <= '0;
         pins_r  <= pins_for(slice_ctl_pkg::ST_IDLE, '0);
      end
      else
      begin
         state_r <= state_nxt;
         pins_r  <= pins_nxt;
         if (accept)
         begin
            cmd_r <= cmd;
         end
      end
   end

   // Restarting the divider on accept gives every phase a full step.
   always_ff @(posedge clk)
   begin
      if (!resetn || accept || step_cnt_r == 3'h0)
      begin
         step_cnt_r <= STEP_CYC - 3'h1;
      end
      else
      begin
         step_cnt_r <= step_cnt_r - 3'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ld_s1_r <= '0;
         ld_s2_r <= '0;
         cm_s1_r <= '1;
         cm_s2_r <= '1;
         co_s1_r <= 2'h3;
         co_s2_r <= 2'h3;
      end
      else
      begin
         ld_s1_r <= local_data_i;
         ld_s2_r <= ld_s1_r;
         cm_s1_r <= compare_match_n;
         cm_s2_r <= cm_s1_r;
         co_s1_r <= {vme_carry_out_n, local_carry_out_n};
         co_s2_r <= co_s1_r;
      end
   end

   // Every slice must report a match; the slice offers no cascade.
   assign merged_match = ~|cm_s2_r;

   // A match is believed only after it has stood steady for the filter
   // time, which hides comparator glitches while the address settles.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         match_prev_r <= 1'b0;
         stab_cnt_r   <= 3'h0;
         addr_match_r <= 1'b0;
      end
      else
      begin
         match_prev_r <= merged_match;
         if (merged_match != match_prev_r)
         begin
            stab_cnt_r <= 3'h0;
         end
         else if (stab_cnt_r != FILT_CYC)
         begin
            stab_cnt_r <= stab_cnt_r + 3'h1;
         end
         else
         begin
            addr_match_r <= match_prev_r;
         end
      end
   end

   assign addr_match      = addr_match_r;
   assign vme_count_max   = !co_s2_r[1];
   assign local_count_max = !co_s2_r[0];
   assign slice_pins      = pins_r;

   byte_fifo #(
      .WIDTH (`SC_BYTE_W),
      .DEPTH (`SC_FIFO_DEPTH)
   ) u_rd_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (ld_s2_r),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_load_decode;
      !pins_r.reg_strobe_n |-> pins_r.bus_request_decode_n;
   endproperty
   a_load_decode: assert property (p_load_decode)
      else $error("Register strobe low while decode low.");

   property p_load_select;
      (!pins_r.reg_strobe_n && cmd_r.op == slice_ctl_pkg::OP_LOAD_CMP)
         == (!pins_r.reg_strobe_n && pins_r.local_data_select);
   endproperty
   a_load_select: assert property (p_load_select)
      else $error("Register select does not follow the load kind.");

   property p_din_hold;
      $rose(pins_r.data_in_latch_ctl) |->
         (!pins_r.data_in_enable_n && !pins_r.data_in_enable2_n) [*8];
   endproperty
   a_din_hold: assert property (p_din_hold)
      else $error("Data-in enables dropped while data is held.");

   property p_dout_hold;
      pins_r.data_out_latch_ctl |->
         !pins_r.data_out_enable_n && pins_r.local_data_oe;
   endproperty
   a_dout_hold: assert property (p_dout_hold)
      else $error("Data-out latch held without data drive.");

   property p_aout_hold;
      $rose(pins_r.addr_out_latch_ctl) && cmd_r.op != slice_ctl_pkg::OP_INC_VME
         |-> !pins_r.vme_addr_out_enable_n ##1 pins_r.addr_out_latch_ctl [*7];
   endproperty
   a_aout_hold: assert property (p_aout_hold)
      else $error("Address latch not held for two phases.");

   property p_vme_inc;
      $rose(pins_r.addr_out_latch_ctl) && cmd_r.op == slice_ctl_pkg::OP_INC_VME
         |-> !pins_r.vme_carry_in_n && !$past(pins_r.vme_carry_in_n, 4);
   endproperty
   a_vme_inc: assert property (p_vme_inc)
      else $error("Bus counter stepped without carry-in set up.");

   property p_local_inc;
      $fell(pins_r.block_xfer_ctl_n) |->
         !pins_r.local_carry_in_n && pins_r.bus_request_decode_n;
   endproperty
   a_local_inc: assert property (p_local_inc)
      else $error("Block control fell without carry-in or with decode low.");

   property p_slave_inc;
      $rose(pins_r.addr_in_latch_ctl) |-> !pins_r.local_carry_in_n;
   endproperty
   a_slave_inc: assert property (p_slave_inc)
      else $error("Slave counter stepped without carry-in.");

   property p_single;
      !pins_r.bus_request_decode_n |-> pins_r.block_xfer_ctl_n;
   endproperty
   a_single: assert property (p_single)
      else $error("Single transfer entered block mode.");

   property p_match_filter;
      $rose(addr_match_r) |-> $past(merged_match, 1) && $past(merged_match, 3);
   endproperty
   a_match_filter: assert property (p_match_filter)
      else $error("Match reported before it stood steady.");

   property p_read_push;
      accept && cmd.op == slice_ctl_pkg::OP_READ |-> ##12 fifo_push;
   endproperty
   a_read_push: assert property (p_read_push)
      else $error("Read data not captured in its phase.");

   c_write: cover property (accept && cmd.op == slice_ctl_pkg::OP_WRITE);
   c_read:  cover property (fifo_push ##[1:40] rd_valid && rd_ready);
   c_match: cover property ($rose(addr_match_r));
   c_full:  cover property (!fifo_in_ready);
endmodule : vme_slice_ctl

// [slice_model.sv]
// Behavioural model of the eight-bit bus slice driven by the controller.
// Assumes the bench resolves the local data wire and drives bus data in.
`timescale 1ns/100ps
module slice_model (
   input  wire slice_ctl_pkg::pins_t p,
   input  wire logic           [7:0] ld,
   input  wire logic           [7:0] vme_d_in,
   input  wire logic                 sel_master,
   output logic                      dev_drv,
   output logic                [7:0] dev_data,
   output logic                [7:0] vme_d_out,
   output logic                [7:0] vme_a_out,
   output logic                      compare_match_n,
   output logic                      vme_carry_out_n,
   output logic                      local_carry_out_n
);
   // Counters start one below terminal count so carries show quickly.
   logic [7:0] mask_r = 8'h00;
   logic [7:0] cmp_r  = 8'hff;
   logic [7:0] vcnt_r = 8'hfe;
   logic [7:0] mcnt_r = 8'hfe;
   logic [7:0] scnt_r = 8'hfe;

   assign dev_drv = !p.data_in_enable_n || !p.data_in_enable2_n;
   always @* if (!p.data_in_latch_ctl) dev_data = vme_d_in;
   always @* if (!p.data_out_latch_ctl) vme_d_out = ld;
   always @* if (!p.addr_out_latch_ctl) vme_a_out = p.local_address;
   always @*
   begin
      if (!p.reg_strobe_n && p.bus_request_decode_n)
      begin
         if (p.local_data_select)
            cmp_r = ld;
         else
            mask_r = ld;
      end
   end
   // Purely combinational, so it glitches while the address moves.
   assign compare_match_n = ~&(~(vme_a_out ^ cmp_r) | mask_r);
   // Dual path is never set by this controller: rising edge only.
   always @(posedge p.addr_out_latch_ctl)
      if (!p.vme_carry_in_n) vcnt_r <= vcnt_r + 8'h01;
   always @(negedge p.block_xfer_ctl_n)
      if (!p.local_carry_in_n && sel_master) mcnt_r <= mcnt_r + 8'h01;
   always @(posedge p.addr_in_latch_ctl)
      if (!p.local_carry_in_n && !sel_master) scnt_r <= scnt_r + 8'h01;
   assign vme_carry_out_n = !(vcnt_r == 8'hff);
   assign local_carry_out_n =
      !((sel_master ? mcnt_r : scnt_r) == 8'hff);
endmodule : slice_model

// [vme_slice_ctl_tb_top.sv]
// Self-checking bench for the slice controller against the slice model.
// Assumes one slice and the default timing counts of the design.
`timescale 1ns/100ps
module vme_slice_ctl_tb_top;
   logic                 clk, resetn, cmd_valid, rd_ready, sel_master;
   slice_ctl_pkg::cmd_t  cmd;
   slice_ctl_pkg::pins_t slice_pins;
   logic                 cmd_ready, rd_valid, busy, addr_match;
   logic                 vme_count_max, local_count_max, dev_drv, vcon, lcon;
   logic           [0:0] cmn;
   logic           [7:0] rd_data, local_data_i, vme_d_in, dev_data;
   logic           [7:0] last_ld = 8'h00;
   logic           [7:0] vme_d_out, vme_a_out, m_dout, m_aout;
   logic                 m_match, m_vmax, m_lmax;
   int                   mismatches, n_compared;

   vme_slice_ctl dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .rd_data(rd_data),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .busy(busy),
      .addr_match(addr_match), .vme_count_max(vme_count_max),
      .local_count_max(local_count_max), .slice_pins(slice_pins),
      .local_data_i(local_data_i), .compare_match_n(cmn),
      .vme_carry_out_n(vcon), .local_carry_out_n(lcon));
   slice_model slice (.p(slice_pins), .ld(local_data_i), .vme_d_in(vme_d_in),
      .sel_master(sel_master), .dev_drv(dev_drv), .dev_data(dev_data),
      .vme_d_out(vme_d_out), .vme_a_out(vme_a_out),
      .compare_match_n(cmn[0]), .vme_carry_out_n(vcon),
      .local_carry_out_n(lcon));

   // An undriven wire must not keep showing its last level.
   assign local_data_i = slice_pins.local_data_oe ? slice_pins.local_data_o :
                         dev_drv ? dev_data : ~last_ld;
   always @(posedge clk) last_ld <= local_data_i;

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (exp !== got)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wait_ready();
      int i;
      for (i = 0; i < 100 && cmd_ready !== 1'b1; i++)
      begin
         @(posedge clk);
         #2;
      end
      if (cmd_ready !== 1'b1)
      begin
         mismatches++;
         $display("wrong value cmd_ready expected 1 seen %b", cmd_ready);
         summarize();
      end
   endtask : wait_ready

   // Issues one command and samples the far side in the last sample cycle.
   task automatic run(slice_ctl_pkg::op_t op, logic [7:0] a, logic [7:0] d);
      wait_ready();
      cmd = '{op: op, addr: a, data: d};
      cmd_valid = 1'b1;
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      repeat (6) @(posedge clk);
      #2;
      if (op == slice_ctl_pkg::OP_READ) vme_d_in = ~vme_d_in;
      repeat (5) @(posedge clk);
      #2;
      m_match = addr_match;
      m_dout = vme_d_out;
      m_aout = vme_a_out;
      m_vmax = vme_count_max;
      m_lmax = local_count_max;
   endtask : run

   task automatic t_reset();
      check("busy", 8'h00, busy);
      check("cmd_ready", 8'h01, cmd_ready);
      check("rd_valid", 8'h00, rd_valid);
      check("addr_match", 8'h00, addr_match);
      check("reg_strobe_n", 8'h01, slice_pins.reg_strobe_n);
   endtask : t_reset

   task automatic t_match_write();
      run(slice_ctl_pkg::OP_LOAD_CMP, 8'h00, 8'h5a);
      run(slice_ctl_pkg::OP_LOAD_MASK, 8'h00, 8'h00);
      run(slice_ctl_pkg::OP_WRITE, 8'h5a, 8'ha5);
      check("match equal", 8'h01, m_match);
      check("bus data", 8'ha5, m_dout);
      check("bus address", 8'h5a, m_aout);
      check("data out latch", 8'h01, slice_pins.data_out_latch_ctl);
      check("addr out latch", 8'h01, slice_pins.addr_out_latch_ctl);
      run(slice_ctl_pkg::OP_WRITE, 8'h5b, 8'h3c);
      check("match differ", 8'h00, m_match);
      run(slice_ctl_pkg::OP_LOAD_MASK, 8'h00, 8'h01);
      run(slice_ctl_pkg::OP_WRITE, 8'h5b, 8'h3c);
      check("match masked", 8'h01, m_match);
   endtask : t_match_write

   task automatic t_read_fifo();
      int i;
      rd_ready = 1'b0;
      for (i = 0; i < 8; i++)
      begin
         vme_d_in = 8'h10 + 8'(i);
         run(slice_ctl_pkg::OP_READ, 8'h00, 8'h00);
      end
      repeat (8) @(posedge clk);
      #2;
      cmd.op = slice_ctl_pkg::OP_READ;
      rd_ready = 1'b1;
      #1;
      check("cmd_ready full", 8'h00, cmd_ready);
      for (i = 0; i < 8; i++)
      begin
         check("rd_valid", 8'h01, rd_valid);
         check("rd_data", 8'h10 + 8'(i), rd_data);
         @(posedge clk);
         #2;
      end
      rd_ready = 1'b0;
      check("rd_valid empty", 8'h00, rd_valid);
   endtask : t_read_fifo

   task automatic t_count();
      run(slice_ctl_pkg::OP_INC_VME, 8'h00, 8'h00);
      check("vme max", 8'h01, m_vmax);
      run(slice_ctl_pkg::OP_INC_VME, 8'h00, 8'h00);
      check("vme wrap", 8'h00, m_vmax);
      sel_master = 1'b1;
      run(slice_ctl_pkg::OP_INC_LOCAL, 8'h00, 8'h00);
      check("local max", 8'h01, m_lmax);
      check("vme still", 8'h00, m_vmax);
      sel_master = 1'b0;
      run(slice_ctl_pkg::OP_INC_SLAVE, 8'h00, 8'h00);
      check("slave max", 8'h01, m_lmax);
      sel_master = 1'b1;
      run(slice_ctl_pkg::OP_INC_LOCAL, 8'h00, 8'h00);
      check("local wrap", 8'h00, m_lmax);
   endtask : t_count

   initial
   begin
      mismatches = 0;
      n_compared = 0;
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      rd_ready = 1'b0;
      sel_master = 1'b1;
      vme_d_in = 8'h00;
      repeat (2) @(posedge clk);
      #2;
      resetn = 1'b1;
      t_reset();
      t_match_write();
      t_read_fifo();
      t_count();
      summarize();
   end
endmodule : vme_slice_ctl_tb_top
